// [pkg/lcd_driver_map.vh]
// Constants of the multiplexed segment display driver: offsets, fields,
// reset values and timing counts. Included by every design file.
`ifndef LCD_DRIVER_MAP_VH
`define LCD_DRIVER_MAP_VH

// ==========================================================================
// Timing
`define MCLK_HZ            25000000
`define DISP_CLK_HZ        256
`define DISP_TICK_CYCLES   (`MCLK_HZ / `DISP_CLK_HZ)

// ==========================================================================
// Register byte offsets
`define LATCH_BASE_OFS     8'h00
`define LATCH_LAST_OFS     8'h3C
`define CTRL1_OFS          8'h44
`define CTRL2_OFS          8'h48
`define STATUS_OFS         8'h4C

// ==========================================================================
// Fields of the first control register
`define CTRL1_BOOST_LSB    0
`define CTRL1_BOOST_W      2
`define CTRL1_RST          2'h0

// ==========================================================================
// Fields of the second control register
`define CTRL2_BLANK_BIT    3
`define CTRL2_POWER_BIT    2
`define CTRL2_FOUR_BIT     1
`define CTRL2_EXT_BIT      0
`define CTRL2_BLANK_RST    1'h1
`define CTRL2_POWER_RST    1'h1
`define CTRL2_FOUR_RST     1'h1
`define CTRL2_EXT_POR      1'h0

// ==========================================================================
// Fields of the status register
`define STAT_PHASE_LSB     0
`define STAT_POL_BIT       4

// ==========================================================================
// Latch allocation defaults: nibble i of the address map is the location
// of latch i, pair i of the bit map its nibble bus bit
`define LATCH_ADDR_DEFAULT 128'h77776666555544443333222211110000
`define LATCH_BIT_DEFAULT  64'hE4E4E4E4E4E4E4E4
`define PRESCALER_TAP_TOP  10

// ==========================================================================
// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [src/display_phase_gen.v]
// Display clock divider and phase sequencer of the segment display driver.
// Assumes mclk at the rate in the map header and a synchronous reset.
`timescale 1ns/1ns
`include "lcd_driver_map.vh"

module display_phase_gen #(
  parameter TICK_CYCLES = `DISP_TICK_CYCLES
) (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       four_phase,
  output reg  [3:0] phase_r,
  output reg        polarity_r,
  output reg        phase_start_r
);

  localparam [3:0]  PH1       = 4'h1;
  localparam [3:0]  PH2       = 4'h2;
  localparam [3:0]  PH3       = 4'h4;
  localparam [3:0]  PH4       = 4'h8;
  localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
  localparam [16:0] TICK_LAST   = TICK_LAST_W[16:0];

  reg  [16:0] div_r;
  reg  [3:0]  phase_nxt;
  wire        tick;

  // ========================================================================
  // Display clock
  assign tick = (div_r == TICK_LAST);

  always @(posedge mclk) begin
    if (!resetn)
      div_r <= 17'h0;
    else if (tick)
      div_r <= 17'h0;
    else
      div_r <= div_r + 17'h1;
  end

  // ========================================================================
  // Phase order; a mode change in phase 3 takes effect at its end
  always @* begin
    case (phase_r)
      PH1:     phase_nxt = PH2;
      PH2:     phase_nxt = PH3;
      PH3:     phase_nxt = four_phase ? PH4 : PH1; // R14
      PH4:     phase_nxt = PH1;
      default: phase_nxt = PH1;
    endcase
  end

  // Two display ticks per phase, one of each polarity
  always @(posedge mclk) begin
    if (!resetn) begin
      phase_r       <= PH1;
      polarity_r    <= 1'b0;
      phase_start_r <= 1'b1;
    end else begin
      phase_start_r <= tick & polarity_r;
      if (tick) begin
        polarity_r <= ~polarity_r; // R2
        if (polarity_r)
          phase_r <= phase_nxt;
      end
    end
  end

endmodule // display_phase_gen

// [src/lcd_segment_multiplex_driver.v]
// Multiplexed segment display driver with an AXI4-Lite register slave.
// Assumes one clock, synchronous resets and prescaler taps in mclk domain.
//
// Operation
// R1: Eight segment terminals, four backplanes: 32 segments 4-phase, 24 in 3-phase.
// R2: Display clock 256 Hz; frame 8 display ticks 4-phase, 6 in 3-phase.
// R3: External bias select disables regulator, multiplier; bias terminals float.
// R4: External bias select is cleared only by power-on reset.
// R5: Four-phase select picks 4 or 3 phases; backplane 4 off in 3-phase.
// R6: Power down stops regulator, multiplier, grounds bias outputs, keeps latches.
// R7: Blank turns all segment terminals off, regulator and multiplier keep running.
// R8: Two-bit booster clock select picks the multiplier clock.
// R9: Select 00,10,01,11 (low bit first) picks taps 10,9,8,7.
// R10: Any system reset sets blank, power down and four-phase select to 1.
// R11: Latch space has 16 nibble locations, 0 to 15.
// R12: Every implemented latch is readable and writable.
// R13: Only 32 latch bits exist; other locations read zero, store nothing.
// R14: Terminal outputs latch n in phase n; phase 4 skipped in 3-phase.
// R15: Backplane n active only in phase n.
// R16: Each latch location chosen at build time.
// R17: Each latch nibble bus bit chosen at build time.
// R18: Latches unused by the display still store written values.
// R19: Default: terminal k, phase j uses location k-1, bit j-1.
// R20: A write reaches the terminal from the next phase that outputs it.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lcd_driver_map.vh"

module lcd_segment_multiplex_driver #(
  parameter         TICK_CYCLES = `DISP_TICK_CYCLES,
  parameter [127:0] ADDR_MAP    = `LATCH_ADDR_DEFAULT,
  parameter [63:0]  BIT_MAP     = `LATCH_BIT_DEFAULT
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        por_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [10:7] prescaler_tap,
  output reg  [7:0]  display_terminal,
  output reg  [3:0]  backplane_drive,
  output reg         drive_polarity,
  output reg  [2:0]  bias_out_en_n,
  output reg         bias_to_ground,
  output reg         regulator_on,
  output reg         booster_clk
);

  localparam [2:0] K_NONE   = 3'h0;
  localparam [2:0] K_LATCH  = 3'h1;
  localparam [2:0] K_CTRL1  = 3'h2;
  localparam [2:0] K_CTRL2  = 3'h3;
  localparam [2:0] K_STATUS = 3'h4;

  // ========================================================================
  // Storage and control state
  reg  [31:0] seg_bits_r;
  reg  [1:0]  booster_clock_select_r;
  reg         segment_blank_r;
  reg         display_power_down_r;
  reg         four_phase_select_r;
  reg         external_bias_select_r;
  reg  [7:0]  seg_data_r;

  reg  [7:0]  aw_addr_r;
  reg         aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_held_r;

  wire        sys_rstn;
  wire [3:0]  phase;
  wire        polarity;
  wire        phase_start;
  wire        do_write;
  wire        do_read;
  wire [2:0]  wr_kind;
  wire [2:0]  rd_kind;
  wire        wr_low;
  wire        drive_on;
  wire [1:0]  tap_idx;
  reg  [7:0]  seg_phase;
  reg  [31:0] rd_word;
  integer     k;
  integer     m;

  // ========================================================================
  // Functions
  // Register class of a byte address
  function [2:0] decode_kind;
    input [7:0] addr;
    begin
      if (addr <= `LATCH_LAST_OFS)
        decode_kind = K_LATCH; // R11
      else if (addr[7:2] == `CTRL1_OFS >> 2)
        decode_kind = K_CTRL1;
      else if (addr[7:2] == `CTRL2_OFS >> 2)
        decode_kind = K_CTRL2;
      else if (addr[7:2] == `STATUS_OFS >> 2)
        decode_kind = K_STATUS;
      else
        decode_kind = K_NONE;
    end
  endfunction

  // Latch idx sits at location loc, nibble bit nb
  function latch_hit;
    input integer idx;
    input [3:0]   loc;
    input [1:0]   nb;
    reg   [127:0] a_sh;
    reg   [63:0]  b_sh;
    begin
      a_sh      = ADDR_MAP >> (idx * 4);
      b_sh      = BIT_MAP >> (idx * 2);
      latch_hit = (a_sh[3:0] == loc) && (b_sh[1:0] == nb); // R16 R17
    end
  endfunction

  // Nibble seen at a latch location; empty bits read zero
  function [3:0] read_loc;
    input [3:0] loc;
    input [31:0] bits;
    integer i;
    integer b;
    begin
      read_loc = 4'h0;
      for (i = 0; i < 32; i = i + 1) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (latch_hit(i, loc, b[1:0]))
            read_loc[b] = read_loc[b] | bits[i]; // R13
        end
      end
    end
  endfunction

  // ========================================================================
  // Phase sequencer
  assign sys_rstn = resetn & por_n;

  display_phase_gen #(
    .TICK_CYCLES   (TICK_CYCLES)
  ) u_phase (
    .mclk          (mclk),
    .resetn        (sys_rstn),
    .four_phase    (four_phase_select_r),
    .phase_r       (phase),
    .polarity_r    (polarity),
    .phase_start_r (phase_start)
  );

  // ========================================================================
  // AXI4-Lite handshakes
  // Address and data are held apart so either may come first
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign do_read       = s_axi_arvalid & ~s_axi_rvalid;
  assign wr_kind       = decode_kind(aw_addr_r);
  assign rd_kind       = decode_kind(s_axi_araddr);
  assign wr_low        = w_strb_r[0];

  always @(posedge mclk) begin
    if (!sys_rstn) begin
      aw_addr_r <= 8'h00;
      aw_held_r <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      w_held_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (!sys_rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_kind == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Latch storage
  // Cleared by power-on only, like the hardware latches they model
  always @(posedge mclk) begin
    if (!por_n) begin
      seg_bits_r <= 32'h0;
    end else if (do_write && wr_kind == K_LATCH && wr_low) begin
      for (k = 0; k < 32; k = k + 1) begin
        if (latch_hit(k, aw_addr_r[5:2], 2'h0))
          seg_bits_r[k] <= w_data_r[0]; // R12 R18
        if (latch_hit(k, aw_addr_r[5:2], 2'h1))
          seg_bits_r[k] <= w_data_r[1];
        if (latch_hit(k, aw_addr_r[5:2], 2'h2))
          seg_bits_r[k] <= w_data_r[2];
        if (latch_hit(k, aw_addr_r[5:2], 2'h3))
          seg_bits_r[k] <= w_data_r[3];
      end
    end
  end

  // ========================================================================
  // Control registers
  always @(posedge mclk) begin
    if (!sys_rstn) begin
      booster_clock_select_r <= `CTRL1_RST;
      segment_blank_r        <= `CTRL2_BLANK_RST; // R10
      display_power_down_r   <= `CTRL2_POWER_RST;
      four_phase_select_r    <= `CTRL2_FOUR_RST;
    end else if (do_write && wr_low) begin
      if (wr_kind == K_CTRL1)
        booster_clock_select_r <= w_data_r[`CTRL1_BOOST_LSB +: `CTRL1_BOOST_W];
      if (wr_kind == K_CTRL2) begin
        segment_blank_r      <= w_data_r[`CTRL2_BLANK_BIT];
        display_power_down_r <= w_data_r[`CTRL2_POWER_BIT];
        four_phase_select_r  <= w_data_r[`CTRL2_FOUR_BIT]; // R5
      end
    end
  end

  // Survives watchdog and other system resets
  always @(posedge mclk) begin
    if (!por_n)
      external_bias_select_r <= `CTRL2_EXT_POR; // R4
    else if (do_write && wr_low && wr_kind == K_CTRL2)
      external_bias_select_r <= w_data_r[`CTRL2_EXT_BIT];
  end

  // ========================================================================
  // Read path
  always @* begin
    rd_word = 32'h0;
    case (rd_kind)
      K_LATCH:
        rd_word[3:0] = read_loc(s_axi_araddr[5:2], seg_bits_r); // R12
      K_CTRL1:
        rd_word[`CTRL1_BOOST_LSB +: `CTRL1_BOOST_W] = booster_clock_select_r;
      K_CTRL2: begin
        rd_word[`CTRL2_BLANK_BIT] = segment_blank_r;
        rd_word[`CTRL2_POWER_BIT] = display_power_down_r;
        rd_word[`CTRL2_FOUR_BIT]  = four_phase_select_r;
        rd_word[`CTRL2_EXT_BIT]   = external_bias_select_r;
      end
      K_STATUS: begin
        rd_word[`STAT_PHASE_LSB +: 4] = phase;
        rd_word[`STAT_POL_BIT]        = polarity;
      end
      default:
        rd_word = 32'h0;
    endcase
  end

  always @(posedge mclk) begin
    if (!sys_rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_kind == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Segment multiplexing
  // Terminal k shows its latch for the current phase
  always @* begin
    seg_phase = 8'h00;
    for (m = 0; m < 8; m = m + 1)
      seg_phase[m] = |(seg_bits_r[m * 4 +: 4] & phase); // R14 R19 R1
  end

  // Sampled only at phase entry so a write waits for its phase
  always @(posedge mclk) begin
    if (!sys_rstn)
      seg_data_r <= 8'h00;
    else if (phase_start)
      seg_data_r <= seg_phase; // R20
  end

  assign drive_on = ~display_power_down_r;

  always @(posedge mclk) begin
    if (!sys_rstn) begin
      display_terminal <= 8'h00;
      backplane_drive  <= 4'h0;
      drive_polarity   <= 1'b0;
    end else begin
      if (segment_blank_r || !drive_on)
        display_terminal <= 8'h00; // R7
      else
        display_terminal <= seg_data_r;
      // Phase 4 never comes up in 3-phase, so backplane 4 stays off
      backplane_drive <= drive_on ? phase : 4'h0; // R15 R5
      drive_polarity  <= drive_on & polarity;
    end
  end

  // ========================================================================
  // Bias supply control
  // Select value counts down from the top tap
  assign tap_idx = booster_clock_select_r;

  always @(posedge mclk) begin
    if (!sys_rstn) begin
      bias_out_en_n  <= 3'h7;
      bias_to_ground <= 1'b0;
      regulator_on   <= 1'b0;
      booster_clk    <= 1'b0;
    end else begin
      regulator_on   <= ~external_bias_select_r & drive_on; // R3 R6
      // External bias wins: its terminals float even while powered down
      bias_out_en_n  <= external_bias_select_r ? 3'h7 : 3'h0; // R3
      bias_to_ground <= ~external_bias_select_r & display_power_down_r; // R6
      if (external_bias_select_r || display_power_down_r)
        booster_clk <= 1'b0;
      else
        booster_clk <= prescaler_tap[`PRESCALER_TAP_TOP - tap_idx]; // R8 R9
    end
  end

endmodule // lcd_segment_multiplex_driver

// [tb/lcd_driver_checker.sv]
// Port checker of the segment display driver.
// Assumes the bench offers write address and data in the same cycle.
`timescale 1ns/1ns
`include "lcd_driver_map.vh"

module lcd_driver_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire        mclk,
  input wire        resetn,
  input wire        por_n,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire [10:7] prescaler_tap,
  input wire [7:0]  display_terminal,
  input wire [3:0]  backplane_drive,
  input wire [2:0]  bias_out_en_n,
  input wire        bias_to_ground,
  input wire        regulator_on,
  input wire        booster_clk
);
  // ====================
  // Shadow of control state
  logic [3:0]  ctl;
  logic [1:0]  bsel;
  logic [7:0]  rad;
  logic [3:0]  bp_q;
  logic [31:0] cnt;
  logic        full_q;
  wire         wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_wstrb[0];

  always @(posedge mclk) begin
    bp_q <= backplane_drive;
    cnt  <= (backplane_drive != bp_q) ? 32'h0 : cnt + 32'h1;
    // Phase length counts only after a change between running phases
    full_q <= (backplane_drive != bp_q) ? (bp_q != 4'h0 && backplane_drive != 4'h0) : full_q;
    if (s_axi_arvalid && s_axi_arready) rad <= s_axi_araddr;
    if (!resetn || !por_n) begin
      ctl[3:1] <= 3'h7;
      bsel     <= 2'h0;
      cnt      <= 32'h0;
      full_q   <= 1'b0;
      // Bias source survives every reset but power-on
      if (!por_n) ctl[0] <= 1'b0;
    end else if (wr && s_axi_awaddr == `CTRL2_OFS) ctl <= s_axi_wdata[3:0];
    else if (wr && s_axi_awaddr == `CTRL1_OFS) bsel <= s_axi_wdata[1:0];
  end

  // ====================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !por_n);

  property p_bp_onehot; $onehot0(backplane_drive); endproperty
  property p_phase_len;
    $changed(backplane_drive) && backplane_drive != 4'h0 && $past(backplane_drive) != 4'h0
      && full_q |-> cnt == 2 * TICK_CYCLES - 1;
  endproperty
  property p_order;
    $changed(backplane_drive) && backplane_drive != 4'h0 && $past(backplane_drive) != 4'h0
      |-> backplane_drive == {$past(backplane_drive[2:0]), 1'b0}
       || (backplane_drive == 4'h1 && $past(backplane_drive) inside {4'h4, 4'h8});
  endproperty
  property p_three; $rose(backplane_drive[3]) |-> ctl[1] || $past(ctl[1], 3); endproperty
  property p_blank; (ctl[3] || ctl[2])[*3] |-> display_terminal == 8'h00; endproperty
  property p_power;
    (ctl[2] && !ctl[0])[*3] |-> bias_to_ground && !regulator_on && !booster_clk
      && backplane_drive == 4'h0;
  endproperty
  property p_ext;
    $stable(ctl[0])[*3] |-> bias_out_en_n == {3{ctl[0]}}
      && (!ctl[0] || (!regulator_on && !booster_clk));
  endproperty
  property p_boost;
    (!ctl[2] && !ctl[0] && $stable(bsel))[*3] |-> booster_clk == $past(prescaler_tap[10 - bsel]);
  endproperty
  property p_empty;
    s_axi_rvalid && rad >= 8'h20 && rad <= 8'h3C |-> s_axi_rdata == 32'h0
      && s_axi_rresp == `RESP_OKAY;
  endproperty

  a_bp_onehot: assert property (p_bp_onehot) else $error("backplane not one-hot");
  a_phase_len: assert property (p_phase_len) else $error("phase length wrong");
  a_order: assert property (p_order) else $error("phase order wrong");
  a_three: assert property (p_three) else $error("fourth backplane in 3-phase");
  a_blank: assert property (p_blank) else $error("terminals on while blanked");
  a_power: assert property (p_power) else $error("power down outputs wrong");
  a_ext: assert property (p_ext) else $error("bias terminal state wrong");
  a_boost: assert property (p_boost) else $error("booster tap wrong");
  a_empty: assert property (p_empty) else $error("empty location not zero");

  c_three: cover property (!ctl[1] && backplane_drive == 4'h4);
  c_empty: cover property (s_axi_rvalid && rad >= 8'h20);
  c_ext: cover property (ctl[0] && bias_out_en_n == 3'h7);
endmodule // lcd_driver_checker

bind lcd_segment_multiplex_driver lcd_driver_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// [tb/display_glass_model.sv]
// Display glass: remembers each segment's state per backplane.
// Assumes one-hot backplanes aligned with the terminal data.
`timescale 1ns/1ns

module display_glass_model (
  input  wire        mclk,
  input  wire [7:0]  display_terminal,
  input  wire [3:0]  backplane_drive,
  output logic [31:0] lit_map
);
  initial lit_map = 32'h0;
  always @(posedge mclk)
    for (int j = 0; j < 4; j++)
      if (backplane_drive[j]) lit_map[j*8 +: 8] <= display_terminal;
endmodule // display_glass_model

// [tb/lcd_segment_multiplex_driver_tb.sv]
// Self-checking bench of the segment display driver.
// Assumes the map header and a shortened display tick.
`timescale 1ns/1ns
`include "lcd_driver_map.vh"

module lcd_segment_multiplex_driver_tb;
  localparam TICK  = 4;
  localparam FRAME = 8 * TICK;
  logic        mclk = 1'b0, resetn = 1'b0, por_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [10:7] prescaler_tap = 4'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  wire         drive_polarity, bias_to_ground, regulator_on, booster_clk;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata, lit_map;
  wire [7:0]   display_terminal;
  wire [3:0]   backplane_drive;
  wire [2:0]   bias_out_en_n;
  int          err_count = 0, num_checks = 0;
  logic [3:0]  lat [16];

  lcd_segment_multiplex_driver #(.TICK_CYCLES(TICK)) u_dut (.*);
  display_glass_model u_glass (.mclk, .display_terminal, .backplane_drive, .lit_map);

  always #20 mclk = ~mclk;
  always @(posedge mclk) prescaler_tap <= prescaler_tap + 4'h1;

  // ====================
  // Shared tasks
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Ready is sampled mid-cycle: it is stable up to the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, bv;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bv) begin
        s_axi_bready <= 1'b0;
        chk("bresp", er, r);
        return;
      end
    end
    chk("bvalid", 1, 0);
    complete_run();
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        chk("rdata", e, d);
        chk("rresp", er, r);
        return;
      end
    end
    chk("rvalid", 1, 0);
    complete_run();
  endtask

  task automatic rst(input logic por);
    @(posedge mclk);
    resetn <= 1'b0;
    por_n  <= !por;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
  endtask

  function automatic logic [31:0] exp_lit();
    for (int j = 0; j < 4; j++)
      for (int k = 0; k < 8; k++)
        exp_lit[j*8+k] = lat[k][j];
  endfunction

  // ====================
  // Scenarios
  task automatic t_latch();
    for (int i = 0; i < 16; i++) begin
      lat[i] = 4'(i * 7 + 3);
      axi_wr(8'(i * 4), {28'hFFFFFFF, lat[i]}, `RESP_OKAY);
    end
    for (int i = 0; i < 16; i++)
      axi_rd(8'(i * 4), (i < 8) ? 32'(lat[i]) : 32'h0, `RESP_OKAY);
    axi_wr(8'h40, 32'h1, `RESP_SLVERR);
    axi_rd(8'h40, 32'h0, `RESP_SLVERR);
  endtask

  task automatic t_display();
    logic pol;
    axi_wr(`CTRL2_OFS, 32'h2, `RESP_OKAY);
    repeat (3 * FRAME) @(posedge mclk);
    @(negedge mclk);
    chk("lit_map", exp_lit(), lit_map);
    pol = drive_polarity;
    repeat (TICK) @(posedge mclk);
    @(negedge mclk);
    chk("polarity", 32'(!pol), 32'(drive_polarity));
    lat[5] = ~lat[5];
    axi_wr(8'h14, 32'(lat[5]), `RESP_OKAY);
    repeat (2 * FRAME) @(posedge mclk);
    @(negedge mclk);
    chk("lit_map", exp_lit(), lit_map);
  endtask

  task automatic t_three();
    int hits;
    hits = 0;
    lat[1] = 4'hC;
    axi_wr(`CTRL2_OFS, 32'h0, `RESP_OKAY);
    axi_wr(8'h04, 32'hC, `RESP_OKAY);
    repeat (FRAME) @(posedge mclk);
    repeat (2 * FRAME) begin
      @(posedge mclk);
      if (backplane_drive[3]) hits++;
    end
    @(negedge mclk);
    chk("phase4", 32'h0, 32'(hits));
    chk("lit_map", exp_lit() & 32'hFFFFFF, lit_map & 32'hFFFFFF);
    axi_rd(8'h04, 32'hC, `RESP_OKAY);
  endtask

  task automatic t_modes();
    axi_wr(`CTRL2_OFS, 32'hA, `RESP_OKAY);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("terminal", 32'h0, display_terminal);
    chk("regulator", 32'h1, regulator_on);
    axi_wr(`CTRL2_OFS, 32'h6, `RESP_OKAY);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("bias_gnd", 32'h1, bias_to_ground);
    chk("regulator", 32'h0, regulator_on);
    chk("polarity", 32'h0, 32'(drive_polarity));
    axi_rd(8'h08, 32'(lat[2]), `RESP_OKAY);
    axi_wr(`CTRL2_OFS, 32'h2, `RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      axi_wr(`CTRL1_OFS, 32'(s), `RESP_OKAY);
      axi_rd(`CTRL1_OFS, 32'(s), `RESP_OKAY);
      repeat (8) @(posedge mclk);
    end
  endtask

  task automatic t_ext();
    axi_wr(`CTRL2_OFS, 32'h1, `RESP_OKAY);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("bias_en_n", 32'h7, bias_out_en_n);
    chk("regulator", 32'h0, regulator_on);
    rst(1'b0);
    axi_rd(`CTRL2_OFS, 32'hF, `RESP_OKAY);
    axi_rd(8'h0C, 32'(lat[3]), `RESP_OKAY);
    rst(1'b1);
    // Phase 1 and low polarity stand for the first display tick after reset
    axi_rd(`STATUS_OFS, 32'h1, `RESP_OKAY);
    axi_rd(`CTRL2_OFS, 32'hE, `RESP_OKAY);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
    axi_rd(`CTRL2_OFS, 32'hE, `RESP_OKAY);
    axi_rd(`CTRL1_OFS, 32'h0, `RESP_OKAY);
    t_latch();
    t_display();
    t_three();
    t_modes();
    t_ext();
    complete_run();
  end
endmodule // lcd_segment_multiplex_driver_tb
